// file: rstfc_cache_tags.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// cache valid bits
// ----------------------------------------
module rstfc_cache_tags #(
    parameter LINES = 16,
    parameter IW = 4
) (
    // clock
    input wire clk_sys_i,
    input wire rst_i,
    input wire ce_i,
    // soft flush and fill
    input wire flush_i,
    input wire fill_i,
    input wire [IW-1:0] idx_i,
    // state
    output wire [LINES-1:0] valid_o
);
    reg [LINES-1:0] valid_r;
    genvar g;
    generate
        for (g = 0; g < LINES; g = g + 1) begin : g_line
            always @(posedge clk_sys_i or posedge rst_i) begin
                if (rst_i) begin
                    valid_r[g] <= 1'b0;
                end else if (ce_i) begin
                    // a fill landing in the flush cycle wins
                    if (fill_i && idx_i == g) begin
                        valid_r[g] <= 1'b1;
                    end else if (flush_i) begin
                        valid_r[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
    assign valid_o = valid_r;
endmodule
`default_nettype wire

// file: rstfc_consts.vh
// How it works
// - reset leaves identification fields in data register
// - first fetch sixteen bytes below address top
// - reset selector F000, base FFFF0000, ip FFF0
// - real mode base is selector shifted four
// - preset base kept until first selector load
// - fpu init: tags empty, masks set, top zero
// - soft init leaves fpu state unchanged
// - hard reset clears trap, monitor, native flags
// - trap flag routes fp instructions to fault
// - monitor flag makes sync honour task switched
// - native flag picks internal or external error
// - trap without emulator hangs on fp instruction
// - cache flags set on reset, enable when clear
// - all cache lines invalid after reset init
// - page cache bits act as per-page controls
// - range registers set region caching behaviour
// - control word 0040 on reset, 037F on init
// - tag word 5555 on reset, FFFF on init
// - caches invalidated on reset, kept on soft init
`ifndef RSTFC_CONSTS_VH
`define RSTFC_CONSTS_VH

// ----------------------------------------
// register offsets (word indices, bus address bits 5:2)
// ----------------------------------------
`define RSTFC_A_CTRL 4'h0
`define RSTFC_A_STAT 4'h1
`define RSTFC_A_FCW 4'h2
`define RSTFC_A_FTW 4'h3
`define RSTFC_A_CSSEL 4'h4
`define RSTFC_A_CSBASE 4'h5
`define RSTFC_A_FETCH 4'h6
`define RSTFC_A_IDENT 4'h7
`define RSTFC_A_RANGE 4'h8
`define RSTFC_A_CACHE 4'h9
`define RSTFC_A_FSW 4'hA

// ----------------------------------------
// control field positions
// ----------------------------------------
`define RSTFC_B_TRAP 0
`define RSTFC_B_MON 1
`define RSTFC_B_NAT 2
`define RSTFC_B_TASK 3
`define RSTFC_B_CD 4
`define RSTFC_B_NW 5
`define RSTFC_B_EMU 6
`define RSTFC_CTRL_W 7
`define RSTFC_CTRL_RST 7'h30

// ----------------------------------------
// reset values
// ----------------------------------------
`define RSTFC_CS_SEL_RST 16'hF000
`define RSTFC_CS_BASE_RST 32'hFFFF0000
`define RSTFC_IP_RST 32'h0000FFF0
`define RSTFC_TOP_GAP 32'h00000010
`define RSTFC_SEG_SHIFT 4
`define RSTFC_FCW_RST 16'h0040
`define RSTFC_FCW_INIT 16'h037F
`define RSTFC_FTW_RST 16'h5555
`define RSTFC_FTW_INIT 16'hFFFF
`define RSTFC_FSW_INIT 16'h0000

// ----------------------------------------
// instruction classes
// ----------------------------------------
`define RSTFC_OP_NONE 2'h0
`define RSTFC_OP_FP 2'h1
`define RSTFC_OP_SYNC 2'h2
`define RSTFC_OP_INIT 2'h3

`endif

// file: rstfc_core.v
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "rstfc_consts.vh"
module rstfc_core #(
    parameter LINES = 16,
    parameter IW = 4,
    parameter [3:0] STEPPING_ID = 4'h1, // arbitrary value
    parameter [3:0] MODEL_ID = 4'h2, // arbitrary value
    parameter [3:0] FAMILY_ID = 4'h3, // arbitrary value
    parameter [1:0] PTYPE_ID = 2'h1, // arbitrary value
    parameter [3:0] EXT_MODEL_ID = 4'h4, // arbitrary value
    parameter [7:0] EXT_FAMILY_ID = 8'h05 // arbitrary value
) (
    // clock and resets
    input wire clk_sys_i,
    input wire rst_i,
    input wire ce_i,
    input wire soft_init_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wb_err_o,
    // instruction stream
    input wire [1:0] instr_op_i,
    input wire selector_load_i,
    input wire [15:0] selector_val_i,
    input wire fp_unmasked_exc_i,
    input wire [1:0] page_bits_i,
    input wire [1:0] range_type_i,
    // results
    output reg nm_fault_o,
    output reg fp_exec_o,
    output reg fp_err_int_o,
    output reg fp_err_ext_o,
    output reg hung_o,
    output reg cache_en_o,
    output reg access_cacheable_o,
    output reg access_wt_o,
    output reg [31:0] fetch_addr_o,
    output reg [31:0] data_reg_d_o
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    reg soft_m_r;
    reg soft_s_r;
    reg soft_d_r;
    reg [`RSTFC_CTRL_W-1:0] control_reg_zero_r;
    reg [15:0] cs_sel_r;
    reg [31:0] cs_base_r;
    reg cs_loaded_r;
    reg [31:0] ip_r;
    reg [15:0] fcw_r;
    reg [15:0] ftw_r;
    reg [15:0] fsw_r;
    reg [2:0] top_r;
    reg [7:0] range_r;
    reg [15:0] hit_cnt_r;
    reg [IW-1:0] fill_idx_r;
    reg hung_r;
    reg soft_seen_r;
    wire [LINES-1:0] line_valid;
    wire soft_pulse = soft_s_r & ~soft_d_r;
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire [3:0] word = wb_adr_i[5:2];
    wire trap_f = control_reg_zero_r[`RSTFC_B_TRAP];
    wire mon_f = control_reg_zero_r[`RSTFC_B_MON];
    wire nat_f = control_reg_zero_r[`RSTFC_B_NAT];
    wire task_f = control_reg_zero_r[`RSTFC_B_TASK];
    wire emu_f = control_reg_zero_r[`RSTFC_B_EMU];
    wire cd_f = control_reg_zero_r[`RSTFC_B_CD];
    wire nw_f = control_reg_zero_r[`RSTFC_B_NW];

    function mapped;
        input [3:0] a;
        begin
            mapped = (a <= `RSTFC_A_FSW);
        end
    endfunction

    // byte-lane merge, used for every writable word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] sel;
        begin
            merge = {sel[3] ? nw[31:24] : old[31:24], sel[2] ? nw[23:16] : old[23:16],
                sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    // ----------------------------------------
    // soft init synchroniser
    // ----------------------------------------
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            soft_m_r <= 1'b0;
            soft_s_r <= 1'b0;
            soft_d_r <= 1'b0;
            soft_seen_r <= 1'b0;
        end else if (ce_i) begin
            soft_m_r <= soft_init_i;
            soft_s_r <= soft_m_r;
            soft_d_r <= soft_s_r;
            // sticky marker only: soft init must leave fpu and caches alone
            if (soft_pulse) begin
                soft_seen_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // instruction classification
    // ----------------------------------------
    wire is_fp = (instr_op_i == `RSTFC_OP_FP) || (instr_op_i == `RSTFC_OP_INIT);
    wire is_sync = (instr_op_i == `RSTFC_OP_SYNC);
    wire fault_fp = is_fp & trap_f;
    wire fault_sync = is_sync & mon_f & task_f;
    // trap set with no emulator present: the core locks up
    wire hang_nxt = fault_fp & ~emu_f;
    wire run_fp = is_fp & ~trap_f & ~hung_r;
    wire do_init = run_fp & (instr_op_i == `RSTFC_OP_INIT);
    wire wr_ctrl = wb_req & wb_we_i & (word == `RSTFC_A_CTRL);
    wire [31:0] ctrl_merged = merge({25'h0000000, control_reg_zero_r}, wb_dat_i, wb_sel_i);
    wire [31:0] range_merged = merge({24'h000000, range_r}, wb_dat_i, wb_sel_i);

    // ----------------------------------------
    // control register, fpu, code segment
    // ----------------------------------------
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            control_reg_zero_r <= `RSTFC_CTRL_RST;
            cs_sel_r <= `RSTFC_CS_SEL_RST;
            cs_base_r <= `RSTFC_CS_BASE_RST;
            cs_loaded_r <= 1'b0;
            ip_r <= `RSTFC_IP_RST;
            fcw_r <= `RSTFC_FCW_RST;
            ftw_r <= `RSTFC_FTW_RST;
            fsw_r <= `RSTFC_FSW_INIT;
            top_r <= 3'h0;
            range_r <= 8'h00;
            hung_r <= 1'b0;
        end else if (ce_i) begin
            if (wr_ctrl) begin
                control_reg_zero_r <= ctrl_merged[`RSTFC_CTRL_W-1:0];
            end
            if (wb_req && wb_we_i && word == `RSTFC_A_RANGE) begin
                range_r <= range_merged[7:0];
            end
            if (hang_nxt) begin
                hung_r <= 1'b1;
            end
            // soft init touches neither fpu nor caches
            if (do_init) begin
                fcw_r <= `RSTFC_FCW_INIT;
                ftw_r <= `RSTFC_FTW_INIT;
                fsw_r <= `RSTFC_FSW_INIT;
                top_r <= 3'h0;
            end
            if (selector_load_i) begin
                cs_sel_r <= selector_val_i;
                cs_base_r <= {12'h000, selector_val_i, 4'h0};
                cs_loaded_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // cache valid array
    // ----------------------------------------
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            fill_idx_r <= {IW{1'b0}};
            hit_cnt_r <= 16'h0000;
        end else if (ce_i && cache_en_o && run_fp) begin
            fill_idx_r <= fill_idx_r + 1'b1;
            if (line_valid[fill_idx_r]) begin
                hit_cnt_r <= hit_cnt_r + 16'h0001;
            end
        end
    end

    rstfc_cache_tags #(
        .LINES(LINES),
        .IW(IW)
    ) u_tags (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .flush_i(1'b0),
        .fill_i(cache_en_o & run_fp),
        .idx_i(fill_idx_r),
        .valid_o(line_valid)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            nm_fault_o <= 1'b0;
            fp_exec_o <= 1'b0;
            fp_err_int_o <= 1'b0;
            fp_err_ext_o <= 1'b0;
            hung_o <= 1'b0;
            cache_en_o <= 1'b0;
            access_cacheable_o <= 1'b0;
            access_wt_o <= 1'b0;
            fetch_addr_o <= `RSTFC_CS_BASE_RST + `RSTFC_IP_RST;
            data_reg_d_o <= 32'h00000000;
        end else if (ce_i) begin
            nm_fault_o <= (fault_fp | fault_sync) & ~hung_r;
            fp_exec_o <= run_fp;
            fp_err_int_o <= run_fp & fp_unmasked_exc_i & nat_f;
            fp_err_ext_o <= run_fp & fp_unmasked_exc_i & ~nat_f;
            hung_o <= hung_r | hang_nxt;
            cache_en_o <= ~cd_f & ~nw_f;
            // range type 0 is cached only when range bit 0 is set; page bits refine per page
            access_cacheable_o <= ~cd_f & ~page_bits_i[1] &
                (range_r[range_type_i] | (range_type_i != 2'h0));
            access_wt_o <= page_bits_i[0] | range_r[{1'b1, range_type_i}];
            fetch_addr_o <= cs_base_r + ip_r;
            data_reg_d_o <= {4'h0, EXT_FAMILY_ID, EXT_MODEL_ID, 2'h0, PTYPE_ID,
                FAMILY_ID, MODEL_ID, STEPPING_ID};
        end
    end

    // ----------------------------------------
    // wishbone answer: one wait cycle
    // ----------------------------------------
    reg [31:0] rd_nxt;
    always @* begin
        rd_nxt = 32'h00000000;
        case (word)
            `RSTFC_A_CTRL: rd_nxt = {25'h0000000, control_reg_zero_r};
            `RSTFC_A_STAT: rd_nxt = {27'h0000000, soft_seen_r, hung_r, cs_loaded_r, cache_en_o,
                nm_fault_o};
            `RSTFC_A_FCW: rd_nxt = {16'h0000, fcw_r};
            `RSTFC_A_FTW: rd_nxt = {16'h0000, ftw_r};
            `RSTFC_A_CSSEL: rd_nxt = {16'h0000, cs_sel_r};
            `RSTFC_A_CSBASE: rd_nxt = cs_base_r;
            `RSTFC_A_FETCH: rd_nxt = fetch_addr_o;
            `RSTFC_A_IDENT: rd_nxt = data_reg_d_o;
            `RSTFC_A_RANGE: rd_nxt = {24'h000000, range_r};
            `RSTFC_A_CACHE: rd_nxt = {hit_cnt_r, {(16-LINES){1'b0}}, line_valid};
            `RSTFC_A_FSW: rd_nxt = {13'h0000, top_r, fsw_r[15:0]} & 32'h0007FFFF;
            default: rd_nxt = 32'h00000000;
        endcase
    end

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            wb_ack_o <= wb_req & mapped(word);
            wb_err_o <= wb_req & ~mapped(word);
            wb_dat_o <= wb_req ? rd_nxt : 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// file: rstfc_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rstfc_core_chk (
    // clock, reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // bus
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // instruction side
    input wire logic [1:0] instr_op_i,
    input wire logic selector_load_i,
    input wire logic [15:0] selector_val_i,
    input wire logic fp_unmasked_exc_i,
    input wire logic [1:0] page_bits_i,
    // results
    input wire logic nm_fault_o,
    input wire logic fp_exec_o,
    input wire logic fp_err_int_o,
    input wire logic fp_err_ext_o,
    input wire logic hung_o,
    input wire logic cache_en_o,
    input wire logic access_cacheable_o,
    input wire logic [31:0] fetch_addr_o
);
// --------------------------------
// shadow of control word, selector
// --------------------------------
logic [6:0] ctrl_r;
logic [15:0] sel_r;
always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
        ctrl_r <= 7'h30;
        sel_r <= 16'hF000;
    end else begin
        if (wb_ack_o && wb_we_i && wb_adr_i[5:2] == 4'h0 && wb_sel_i[0])
            ctrl_r <= wb_dat_i[6:0];
        if (selector_load_i)
            sel_r <= selector_val_i;
    end
end
default clocking cb @(posedge clk_sys_i);
endclocking
default disable iff (rst_i);
a_fp_exec: assert property (ce_i && instr_op_i == 2'h1 && !ctrl_r[0] && !hung_o
    |=> fp_exec_o && !nm_fault_o) else $error("fp instruction not executed");
a_fp_trap: assert property (ce_i && instr_op_i == 2'h1 && ctrl_r[0] && ctrl_r[6]
    |=> nm_fault_o && !fp_exec_o) else $error("trap flag gave no fault");
a_trap_hang: assert property (ce_i && instr_op_i == 2'h1 && ctrl_r[0] && !ctrl_r[6]
    |=> hung_o) else $error("no hang without emulator");
a_sync_task: assert property (ce_i && instr_op_i == 2'h2 && !ctrl_r[0] && !hung_o
    |=> nm_fault_o == (ctrl_r[1] && ctrl_r[3])) else $error("sync fault wrong");
a_err_route: assert property (ce_i && instr_op_i == 2'h1 && !ctrl_r[0] && fp_unmasked_exc_i
    |=> fp_err_int_o == ctrl_r[2] && fp_err_ext_o == !ctrl_r[2]) else $error("error path wrong");
a_cache_en: assert property (cache_en_o == !(ctrl_r[4] || ctrl_r[5]))
    else $error("cache enable wrong");
a_page_pcd: assert property (ce_i && page_bits_i[1] |=> !access_cacheable_o)
    else $error("page cache disable ignored");
a_reset_fetch: assert property ($fell(rst_i) |-> fetch_addr_o == 32'hFFFFFFF0)
    else $error("reset fetch address wrong");
a_sel_base: assert property (selector_load_i
    |-> ##[1:2] fetch_addr_o == {12'h000, sel_r, 4'h0} + 32'h0000FFF0)
    else $error("selector base wrong");
endmodule
bind rstfc_core rstfc_core_chk u_chk (.clk_sys_i, .rst_i, .ce_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_ack_o, .instr_op_i, .selector_load_i, .selector_val_i, .fp_unmasked_exc_i,
    .page_bits_i, .nm_fault_o, .fp_exec_o, .fp_err_int_o, .fp_err_ext_o, .hung_o, .cache_en_o,
    .access_cacheable_o, .fetch_addr_o);
`default_nettype wire

// file: rstfc_irq_model.sv
`timescale 1ns/1ps
`default_nettype none
module rstfc_irq_model (
    // clock, reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // external error line
    input wire logic fp_err_ext_i,
    output logic [7:0] irq_cnt_o
);
always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
        irq_cnt_o <= 8'h00;
    else if (fp_err_ext_i)
        irq_cnt_o <= irq_cnt_o + 8'h01;
end
endmodule
`default_nettype wire

// file: test_cpu_reset_fpu_cache_init.sv
`timescale 1ns/1ps
`default_nettype none
module test_cpu_reset_fpu_cache_init;
logic clk_sys_i = 0, rst_i = 1, soft_init_i = 0, cyc = 0, we = 0, ld = 0, exc = 0, e_seen;
logic ena = 1;
logic [5:0] adr = 0;
logic [31:0] wdat = 0, q;
logic [1:0] op = 0, pb = 0, rt = 0;
logic [15:0] sv = 0;
logic [7:0] irq_n;
wire [31:0] rdat, fa, id;
wire ack, err, nm, ex, ei, ee, hg, ce, ac, wt;
int err_total = 0, checks_done = 0, cyc_n = 0;
always #5 clk_sys_i = ~clk_sys_i;
rstfc_core uut (.clk_sys_i, .rst_i, .ce_i(ena), .soft_init_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .instr_op_i(op), .selector_load_i(ld),
    .selector_val_i(sv), .fp_unmasked_exc_i(exc), .page_bits_i(pb), .range_type_i(rt),
    .nm_fault_o(nm), .fp_exec_o(ex), .fp_err_int_o(ei), .fp_err_ext_o(ee), .hung_o(hg),
    .cache_en_o(ce), .access_cacheable_o(ac), .access_wt_o(wt), .fetch_addr_o(fa),
    .data_reg_d_o(id));
rstfc_irq_model pic (.clk_sys_i, .rst_i, .fp_err_ext_i(ee), .irq_cnt_o(irq_n));
// --------------------------------
// helpers
// --------------------------------
function automatic logic [31:0] ident_exp();
    return {4'h0, 8'h05, 4'h4, 2'h0, 2'h1, 4'h3, 4'h2, 4'h1};
endfunction
function automatic logic [31:0] fetch_exp(input logic [15:0] s);
    return {12'h000, s, 4'h0} + 32'h0000FFF0;
endfunction
task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
        err_total++;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task results;
    $display("checks=%0d errors=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask
// one classic cycle, held until ack or err is sampled
task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    cyc <= 1;
    we <= w;
    adr <= {a, 2'b00};
    wdat <= d;
    @(posedge clk_sys_i iff (ack | err));
    q = rdat;
    e_seen = err;
    cyc <= 0;
endtask
task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(q & m, x);
endtask
task run_op(input logic [1:0] o, input logic x);
    @(posedge clk_sys_i);
    op <= o;
    exc <= x;
    @(posedge clk_sys_i);
    op <= 2'h0;
    exc <= 1'b0;
    #1;
endtask
always @(posedge clk_sys_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
        err_total++;
        results();
    end
end
// --------------------------------
// main sequence
// --------------------------------
initial begin
    void'($urandom(32'hB88DCAC2));
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 0;
    @(posedge clk_sys_i);
    #1;
    chk(fa, 32'hFFFFFFF0);
    chk(id, ident_exp());
    chk({31'h0, ce}, 32'h0);
    rd(4'h0, 32'h7F, 32'h30);
    rd(4'h2, 32'hFFFF, 32'h0040);
    rd(4'h3, 32'hFFFF, 32'h5555);
    rd(4'h4, 32'hFFFF, 32'hF000);
    rd(4'h5, 32'hFFFFFFFF, 32'hFFFF0000);
    rd(4'h9, 32'hFFFF, 32'h0);
    bus(1'b0, 4'hF, 32'h0);
    chk({31'h0, e_seen}, 32'h1);
    run_op(2'h1, 1'b0);
    chk({30'h0, nm, ex}, 32'h1);
    run_op(2'h2, 1'b0);
    chk({31'h0, nm}, 32'h0);
    bus(1'b1, 4'h0, 32'h3A);
    run_op(2'h2, 1'b0);
    chk({31'h0, nm}, 32'h1);
    bus(1'b1, 4'h0, 32'h34);
    run_op(2'h1, 1'b1);
    chk({30'h0, ei, ee}, 32'h2);
    bus(1'b1, 4'h0, 32'h30);
    run_op(2'h1, 1'b1);
    chk({30'h0, ei, ee}, 32'h1);
    run_op(2'h3, 1'b0);
    chk({24'h0, irq_n}, 32'h1);
    rd(4'h2, 32'hFFFF, 32'h037F);
    rd(4'h3, 32'hFFFF, 32'hFFFF);
    rd(4'hA, 32'h7FFFF, 32'h0);
    bus(1'b1, 4'h0, 32'h00);
    run_op(2'h1, 1'b0);
    run_op(2'h1, 1'b0);
    @(posedge clk_sys_i);
    soft_init_i <= 1;
    repeat (2) @(posedge clk_sys_i);
    soft_init_i <= 0;
    repeat (6) @(posedge clk_sys_i);
    rd(4'h2, 32'hFFFF, 32'h037F);
    rd(4'h3, 32'hFFFF, 32'hFFFF);
    rd(4'h9, 32'hFFFFFFFF, 32'h3);
    rd(4'h1, 32'h10, 32'h10);
    bus(1'b1, 4'h8, 32'h1E);
    chk({31'h0, ce}, 32'h1);
    repeat (8) begin
        @(posedge clk_sys_i);
        pb <= 2'($urandom);
        rt <= 2'($urandom);
        @(posedge clk_sys_i);
        #1;
        chk({30'h0, ac, wt}, {30'h0, !pb[1] && rt != 2'h0, pb[0] || rt == 2'h0});
    end
    repeat (4) begin
        @(posedge clk_sys_i);
        ld <= 1;
        sv <= 16'($urandom);
        @(posedge clk_sys_i);
        ld <= 0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(fa, fetch_exp(sv));
        rd(4'h5, 32'hFFFFFFFF, {12'h000, sv, 4'h0});
    end
    bus(1'b1, 4'h0, 32'h45);
    run_op(2'h1, 1'b0);
    chk({31'h0, nm}, 32'h1);
    bus(1'b1, 4'h0, 32'h01);
    run_op(2'h1, 1'b0);
    chk({31'h0, hg}, 32'h1);
    @(posedge clk_sys_i);
    rst_i <= 1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 0;
    @(posedge clk_sys_i);
    #1;
    chk(fa, 32'hFFFFFFF0);
    rd(4'h0, 32'h7F, 32'h30);
    rd(4'h1, 32'h1F, 32'h0);
    @(posedge clk_sys_i);
    ena <= 0;
    run_op(2'h1, 1'b0);
    chk({31'h0, ex}, 32'h0);
    @(posedge clk_sys_i);
    ena <= 1;
    run_op(2'h1, 1'b0);
    chk({31'h0, ex}, 32'h1);
    results();
end
endmodule
`default_nettype wire
